/* dv/agrc_host_model.sv */
`default_nettype none
module agrc_host_model (
    input  wire logic       clock,
    output logic      [3:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd,
    input  wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // callers keep control bit 7 and revision bits 2:0 at zero
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // data only stand for one cycle, so sample mid-cycle
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] REV = 4'h5; // arbitrary value
    localparam logic [191:0] TRIM = {24'h400700, 24'h400600, 24'h400500, 24'h400400,
                                     24'h400300, 24'h400200, 24'h400100, 24'h400000};
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, b;
    logic wr, rd, resultValid, readyN, sharedPin;
    logic convValid = 1'b0;
    logic serialData = 1'b0;
    logic stopMode = 1'b0;
    logic signed [23:0] convData = 24'h000000;
    logic signed [23:0] resultData;
    logic [2:0] gainSelect;
    logic [11:0] rateSps;
    logic [23:0] v;
    int errors = 0;
    int checks_done = 0;
    agrc_regs #(.REVISION(REV), .FS_TRIM(TRIM)) u_agrc_regs (.clock(clock), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .convValid(convValid),
        .convData(convData), .serialData(serialData), .stoppedContinuousReadMode(stopMode),
        .resultData(resultData), .resultValid(resultValid), .gainSelect(gainSelect),
        .rateSps(rateSps), .dedicatedReadyPinN(readyN), .sharedOutputPin(sharedPin));
    agrc_host_model u_agrc_host_model (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    initial begin
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic rd24(input logic [3:0] a);
        for (int i = 0; i < 3; i++) begin
            u_agrc_host_model.rd_reg(a + 4'(i), b);
            v[8*i +: 8] = b;
        end
    endtask
    task automatic wr24(input logic [3:0] a, input logic [23:0] d);
        for (int i = 0; i < 3; i++)
            u_agrc_host_model.wr_reg(a + 4'(i), d[8*i +: 8]);
    endtask
    // result then ready: the pin falls the cycle after the result pulse
    task automatic convert(input logic [23:0] d, input logic [23:0] exp);
        int n;
        @(posedge clock);
        convValid <= 1'b1;
        convData <= d;
        @(posedge clock);
        convValid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (resultValid !== 1'b1 && n < 4);
        if (n >= 4) begin
            errors++;
            $display("Error %0t: no result", $time);
            end_of_test();
        end
        chk(resultData, exp);
        @(negedge clock);
        chk(24'(readyN), 24'h0);
    endtask
    task automatic t_reset;
        chk(24'(readyN), 24'h1);
        chk(24'(gainSelect), 24'h0);
        chk(24'(rateSps), 24'h000005);
        u_agrc_host_model.rd_reg(4'h3, b);
        chk(24'(b), 24'h00);
        rd24(4'h4);
        chk(v, 24'h000000);
        rd24(4'h7);
        chk(v, TRIM[23:0]);
        u_agrc_host_model.rd_reg(4'ha, b);
        chk(24'(b), {16'h0, REV, 4'h0});
    endtask
    task automatic t_ctrl;
        for (int i = 0; i < 16; i++) begin
            u_agrc_host_model.wr_reg(4'h3, {1'b0, 3'(i), 4'(i)});
            @(negedge clock);
            v = i > 8 ? 24'h0007d0 : (i == 8 ? 24'h0003e8 : 24'h000005 << i);
            chk(24'(rateSps), v);
            chk(24'(gainSelect), 24'(i % 8));
            u_agrc_host_model.rd_reg(4'h3, b);
            chk(24'(b), 24'(i % 8 * 16 + i));
            rd24(4'h7);
            chk(v, TRIM[24*(i%8) +: 24]);
        end
    endtask
    task automatic t_calib;
        u_agrc_host_model.wr_reg(4'h3, 8'h00);
        convert(24'h123456, 24'h123456);
        wr24(4'h4, 24'hfffff0);
        rd24(4'h4);
        chk(v, 24'hfffff0);
        convert(24'h000100, 24'h000110);
        wr24(4'h7, 24'h800000);
        convert(24'h400000, 24'h7fffff);
        convert(24'hbfff00, 24'h800000);
        wr24(4'h7, 24'h200000);
        convert(24'h000100, 24'h000088);
    endtask
    task automatic drive_pins(input logic sd, input logic stop);
        @(posedge clock);
        serialData <= sd;
        stopMode <= stop;
        @(negedge clock);
    endtask
    task automatic t_ready;
        u_agrc_host_model.wr_reg(4'ha, 8'hf8);
        u_agrc_host_model.rd_reg(4'ha, b);
        chk(24'(b), {16'h0, REV, 4'h8});
        chk(24'(sharedPin), 24'h1);
        convert(24'h000010, 24'h000010);
        drive_pins(1'b1, 1'b0);
        chk(24'(sharedPin), 24'h1);
        drive_pins(1'b0, 1'b0);
        chk(24'(sharedPin), 24'h0);
        u_agrc_host_model.rd_reg(4'ha, b);
        chk(24'(readyN), 24'h1);
        drive_pins(1'b0, 1'b1);
        chk(24'(sharedPin), 24'h0);
        drive_pins(1'b0, 1'b0);
        chk(24'(sharedPin), 24'h1);
        u_agrc_host_model.wr_reg(4'ha, 8'h00);
        @(negedge clock);
        chk(24'(sharedPin), 24'h0);
        convert(24'h000010, 24'h000010);
        drive_pins(1'b1, 1'b0);
        chk(24'(sharedPin), 24'h1);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_ctrl();
        t_calib();
        t_ready();
        end_of_test();
    end
endmodule
`default_nettype wire

/* rtl/agrc_pkg.sv */
`default_nettype none
package agrc_pkg;
    localparam logic [3:0]  ADDR_CTRL   = 4'h3;
    localparam logic [3:0]  ADDR_OFS_LO = 4'h4;
    localparam logic [3:0]  ADDR_OFS_MI = 4'h5;
    localparam logic [3:0]  ADDR_OFS_HI = 4'h6;
    localparam logic [3:0]  ADDR_FS_LO  = 4'h7;
    localparam logic [3:0]  ADDR_FS_MI  = 4'h8;
    localparam logic [3:0]  ADDR_FS_HI  = 4'h9;
    localparam logic [3:0]  ADDR_REV    = 4'ha;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [23:0] OFS_RESET   = 24'h000000;
    localparam int          FS_UNITY_SH = 22;
    localparam int          GAIN_LSB    = 4;
    localparam int          MODE_BIT    = 3;
    localparam int          REV_LSB     = 4;
    // output rate in SPS per rate_select code
    function automatic logic [11:0] rate_sps(input logic [3:0] code);
        logic [11:0] r;
        r = 12'h000;
        unique case (code)
            4'h0: r = 12'h005;
            4'h1: r = 12'h00a;
            4'h2: r = 12'h014;
            4'h3: r = 12'h028;
            4'h4: r = 12'h050;
            4'h5: r = 12'h0a0;
            4'h6: r = 12'h140;
            4'h7: r = 12'h280;
            4'h8: r = 12'h3e8;
            default: r = 12'h7d0;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

/* rtl/agrc_regs.sv */
`default_nettype none
module agrc_regs #(
    parameter logic [3:0]   REVISION = 4'h1, // arbitrary value
    parameter logic [191:0] FS_TRIM  = {8{24'h400000}}
) (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic [3:0]         addr,
    input  wire logic [7:0]         wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic      [7:0]         rdata,
    input  wire logic               convValid,
    input  wire logic signed [23:0] convData,
    input  wire logic               serialData,
    input  wire logic               stoppedContinuousReadMode,
    output logic signed [23:0]      resultData,
    output logic                    resultValid,
    output logic      [2:0]         gainSelect,
    output logic      [11:0]        rateSps,
    output logic                    dedicatedReadyPinN,
    output logic                    sharedOutputPin
);
    logic [2:0]  gain_q;
    logic [3:0]  rate_q;
    logic [23:0] ofs_q;
    logic [23:0] fs_q;
    logic        mode_q;
    logic [7:0]  rdata_q;
    logic        readyN_q;
    logic signed [23:0] res_q;
    logic        resV_q;
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] scaled;
    logic [23:0] trim;
    logic [11:0] rateSps_q;

    // gain write decoded here so reload is same edge as the change
    logic gainWr;
    logic [2:0] newGain;
    assign gainWr  = wr && addr == agrc_pkg::ADDR_CTRL;
    assign newGain = wdata[agrc_pkg::GAIN_LSB +: 3];
    assign trim    = FS_TRIM[newGain*24 +: 24];

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gain_q <= agrc_pkg::CTRL_RESET[6:4];
            rate_q <= agrc_pkg::CTRL_RESET[3:0];
        end else if (gainWr) begin
            gain_q <= newGain;
            rate_q <= wdata[3:0];
        end
    end

    // decoded at write time so the rate output comes straight from a flop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rateSps_q <= agrc_pkg::rate_sps(agrc_pkg::CTRL_RESET[3:0]);
        end else if (gainWr) begin
            rateSps_q <= agrc_pkg::rate_sps(wdata[3:0]);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ofs_q <= agrc_pkg::OFS_RESET;
        end else if (wr) begin
            if (addr == agrc_pkg::ADDR_OFS_LO) ofs_q[7:0] <= wdata;
            if (addr == agrc_pkg::ADDR_OFS_MI) ofs_q[15:8] <= wdata;
            if (addr == agrc_pkg::ADDR_OFS_HI) ofs_q[23:16] <= wdata;
        end
    end

    // reset content is the gain-0 trim
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fs_q <= FS_TRIM[23:0];
        end else if (gainWr && newGain != gain_q) begin
            fs_q <= trim;
        end else if (wr) begin
            if (addr == agrc_pkg::ADDR_FS_LO) fs_q[7:0] <= wdata;
            if (addr == agrc_pkg::ADDR_FS_MI) fs_q[15:8] <= wdata;
            if (addr == agrc_pkg::ADDR_FS_HI) fs_q[23:16] <= wdata;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_q <= 1'b0;
        end else if (wr && addr == agrc_pkg::ADDR_REV) begin
            mode_q <= wdata[agrc_pkg::MODE_BIT];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                agrc_pkg::ADDR_CTRL:   rdata_q <= {1'b0, gain_q, rate_q};
                agrc_pkg::ADDR_OFS_LO: rdata_q <= ofs_q[7:0];
                agrc_pkg::ADDR_OFS_MI: rdata_q <= ofs_q[15:8];
                agrc_pkg::ADDR_OFS_HI: rdata_q <= ofs_q[23:16];
                agrc_pkg::ADDR_FS_LO:  rdata_q <= fs_q[7:0];
                agrc_pkg::ADDR_FS_MI:  rdata_q <= fs_q[15:8];
                agrc_pkg::ADDR_FS_HI:  rdata_q <= fs_q[23:16];
                agrc_pkg::ADDR_REV:    rdata_q <= {REVISION, mode_q, 3'b000};
                default:               rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;

    // correction: subtract offset, then scale by fs / 2^22
    assign diff   = 25'(convData) - 25'($signed(ofs_q));
    assign prod   = 50'(diff) * $signed({1'b0, fs_q});
    assign scaled = prod >>> agrc_pkg::FS_UNITY_SH;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            res_q  <= 24'sh000000;
            resV_q <= 1'b0;
        end else begin
            resV_q <= convValid;
            if (convValid) begin
                // saturate instead of wrapping on overrange
                if (scaled > 50'sh7fffff) res_q <= 24'sh7fffff;
                else if (scaled < -50'sh800000) res_q <= -24'sh800000;
                else res_q <= scaled[23:0];
            end
        end
    end
    assign resultData  = res_q;
    assign resultValid = resV_q;

    // ready low from new result until the next register read or write clears it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readyN_q <= 1'b1;
        end else if (resV_q) begin
            readyN_q <= 1'b0;
        end else if (rd || wr) begin
            readyN_q <= 1'b1;
        end
    end
    assign dedicatedReadyPinN = readyN_q;
    // combined pin unsupported in stopped continuous read mode
    assign sharedOutputPin = (mode_q && !stoppedContinuousReadMode && readyN_q)
                             ? 1'b1 : serialData;
    assign gainSelect = gain_q;
    assign rateSps    = rateSps_q;

    property p_rdzero;
        @(posedge clock) disable iff (!nrst)
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdzero: assert property (p_rdzero) else $error("idle read data not zero");

    property p_reload;
        @(posedge clock) disable iff (!nrst)
        (gainWr && newGain != gain_q) |=> fs_q == $past(trim);
    endproperty
    a_reload: assert property (p_reload) else $error("fullscale not reloaded");

    property p_ready;
        @(posedge clock) disable iff (!nrst)
        resV_q |=> !dedicatedReadyPinN;
    endproperty
    a_ready: assert property (p_ready) else $error("ready pin not low");

    property p_rev;
        @(posedge clock) disable iff (!nrst)
        (rd && addr == agrc_pkg::ADDR_REV) |=> rdata[7:4] == REVISION && rdata[2:0] == 3'b000;
    endproperty
    a_rev: assert property (p_rev) else $error("revision read wrong");

    // conversion flow steps: raw sample, corrected result, ready pin low
    sequence s_rawIn;
        convValid;
    endsequence

    sequence s_resultOut;
        resultValid;
    endsequence

    sequence s_readyLow;
        !dedicatedReadyPinN;
    endsequence

    property p_convflow;
        @(posedge clock) disable iff (!nrst)
        s_rawIn |=> s_resultOut ##1 s_readyLow;
    endproperty
    a_convflow: assert property (p_convflow) else $error("conversion flow broken");

    property p_gainset;
        @(posedge clock) disable iff (!nrst)
        gainWr |=> gainSelect == $past(newGain);
    endproperty
    a_gainset: assert property (p_gainset) else $error("gain not taken");

    property p_gainhold;
        @(posedge clock) disable iff (!nrst)
        !gainWr |=> $stable(gainSelect);
    endproperty
    a_gainhold: assert property (p_gainhold) else $error("gain moved without write");

    property p_ratelow;
        @(posedge clock) disable iff (!nrst)
        (gainWr && !wdata[3]) |=> rateSps == (12'h005 << $past(wdata[2:0]));
    endproperty
    a_ratelow: assert property (p_ratelow) else $error("low rate not doubling");

    property p_rate1000;
        @(posedge clock) disable iff (!nrst)
        (gainWr && wdata[3:0] == 4'h8) |=> rateSps == 12'h3e8;
    endproperty
    a_rate1000: assert property (p_rate1000) else $error("rate code 8 wrong");

    property p_rate2000;
        @(posedge clock) disable iff (!nrst)
        (gainWr && wdata[3] && wdata[2:0] != 3'h0) |=> rateSps == 12'h7d0;
    endproperty
    a_rate2000: assert property (p_rate2000) else $error("top rate codes wrong");

    property p_ofslo;
        @(posedge clock) disable iff (!nrst)
        (wr && addr == agrc_pkg::ADDR_OFS_LO) |=> ofs_q[7:0] == $past(wdata);
    endproperty
    a_ofslo: assert property (p_ofslo) else $error("offset low byte lost");

    property p_ofshi;
        @(posedge clock) disable iff (!nrst)
        (wr && addr == agrc_pkg::ADDR_OFS_HI) |=> ofs_q[23:16] == $past(wdata);
    endproperty
    a_ofshi: assert property (p_ofshi) else $error("offset high byte lost");

    property p_fslo;
        @(posedge clock) disable iff (!nrst)
        (wr && addr == agrc_pkg::ADDR_FS_LO) |=> fs_q[7:0] == $past(wdata);
    endproperty
    a_fslo: assert property (p_fslo) else $error("fullscale low byte lost");

    property p_fshi;
        @(posedge clock) disable iff (!nrst)
        (wr && addr == agrc_pkg::ADDR_FS_HI) |=> fs_q[23:16] == $past(wdata);
    endproperty
    a_fshi: assert property (p_fshi) else $error("fullscale high byte lost");

    property p_samegain;
        @(posedge clock) disable iff (!nrst)
        (gainWr && newGain == gain_q) |=> $stable(fs_q);
    endproperty
    a_samegain: assert property (p_samegain) else $error("fullscale reloaded");

    property p_modewr;
        @(posedge clock) disable iff (!nrst)
        (wr && addr == agrc_pkg::ADDR_REV) |=> mode_q == $past(wdata[agrc_pkg::MODE_BIT]);
    endproperty
    a_modewr: assert property (p_modewr) else $error("ready mode not taken");

    property p_ctrlrd;
        @(posedge clock) disable iff (!nrst)
        (rd && addr == agrc_pkg::ADDR_CTRL) |=> !rdata[7];
    endproperty
    a_ctrlrd: assert property (p_ctrlrd) else $error("control bit 7 set");

    property p_unity;
        @(posedge clock) disable iff (!nrst)
        (convValid && ofs_q == agrc_pkg::OFS_RESET
            && fs_q == 24'h000001 << agrc_pkg::FS_UNITY_SH)
            |=> resultData == $past(convData);
    endproperty
    a_unity: assert property (p_unity) else $error("unity result altered");

    property p_noconv;
        @(posedge clock) disable iff (!nrst)
        !convValid |=> $stable(resultData);
    endproperty
    a_noconv: assert property (p_noconv) else $error("result moved");

    property p_readyclr;
        @(posedge clock) disable iff (!nrst)
        ((rd || wr) && !resV_q) |=> dedicatedReadyPinN;
    endproperty
    a_readyclr: assert property (p_readyclr) else $error("ready not cleared");

    property p_readyhold;
        @(posedge clock) disable iff (!nrst)
        (!resV_q && !rd && !wr) |=> $stable(dedicatedReadyPinN);
    endproperty
    a_readyhold: assert property (p_readyhold) else $error("ready moved");

    property p_sharedfree;
        @(posedge clock) disable iff (!nrst)
        (!mode_q || stoppedContinuousReadMode) |-> sharedOutputPin == serialData;
    endproperty
    a_sharedfree: assert property (p_sharedfree) else $error("pin not data");

    property p_sharedidle;
        @(posedge clock) disable iff (!nrst)
        (mode_q && !stoppedContinuousReadMode && dedicatedReadyPinN) |-> sharedOutputPin;
    endproperty
    a_sharedidle: assert property (p_sharedidle) else $error("pin not idle high");
endmodule
`default_nettype wire
